/* rtl/usbg_pkg.sv */
// Package of request codes, field positions, reset values and state types for the get-request responder.
package usbg_pkg;

  // Request codes handled or watched by the responder.
  localparam logic [7:0] USBG_REQ_GET_STATUS    = 8'h00;
  localparam logic [7:0] USBG_REQ_CLEAR_FEATURE = 8'h01;
  localparam logic [7:0] USBG_REQ_SET_FEATURE   = 8'h03;
  localparam logic [7:0] USBG_REQ_GET_DESCR     = 8'h06;
  localparam logic [7:0] USBG_REQ_GET_CONFIG    = 8'h08;
  localparam logic [7:0] USBG_REQ_GET_IFACE     = 8'h0a;

  // Descriptor type codes.
  localparam logic [7:0] USBG_DT_DEVICE    = 8'h01;
  localparam logic [7:0] USBG_DT_CONFIG    = 8'h02;
  localparam logic [7:0] USBG_DT_STRING    = 8'h03;
  localparam logic [7:0] USBG_DT_QUALIFIER = 8'h06;
  localparam logic [7:0] USBG_DT_OTHER_CFG = 8'h07;

  // Feature selectors.
  localparam logic [15:0] USBG_FS_EP_HALT   = 16'h0000;
  localparam logic [15:0] USBG_FS_WAKEUP    = 16'h0001;
  localparam logic [15:0] USBG_FS_TEST_MODE = 16'h0002;

  // Request type field layout and codes.
  localparam int         USBG_RT_DIR_BIT  = 7;
  localparam int         USBG_RT_TYPE_LSB = 5;
  localparam logic [1:0] USBG_RT_STANDARD = 2'h0;
  localparam logic [4:0] USBG_RCP_DEVICE  = 5'h00;
  localparam logic [4:0] USBG_RCP_IFACE   = 5'h01;
  localparam logic [4:0] USBG_RCP_EP      = 5'h02;

  // Status word bit positions.
  localparam int USBG_ST_SELF_PWR_BIT = 0;
  localparam int USBG_ST_WAKEUP_BIT   = 1;
  localparam int USBG_ST_HALT_BIT     = 0;

  // Reset values of the kept status bits.
  localparam logic USBG_WAKEUP_RESET = 1'b0;
  localparam logic USBG_HALT_RESET   = 1'b0;

  // Lengths of the fixed-size answers.
  localparam logic [15:0] USBG_LEN_ONE = 16'h0001;
  localparam logic [15:0] USBG_LEN_TWO = 16'h0002;

  // Device state as reported by the enumeration logic.
  typedef enum logic [1:0] {
    USBG_ST_DEFAULT    = 2'b00,
    USBG_ST_ADDRESS    = 2'b01,
    USBG_ST_CONFIGURED = 2'b10
  } usbg_dev_state_type;

  // Responder sequencer states.
  typedef enum logic [2:0] {
    USBG_FSM_IDLE   = 3'b000,
    USBG_FSM_LOOKUP = 3'b001,
    USBG_FSM_FETCH  = 3'b010,
    USBG_FSM_SEND   = 3'b011,
    USBG_FSM_ZLP    = 3'b100
  } usbg_fsm_type;

endpackage

/* rtl/usbg_get_responder.sv */
// Control-pipe responder for the read-type standard requests and the endpoint status bits.
`timescale 1ns/100ps
module usbg_get_responder
  import usbg_pkg::*;
#(
  parameter int NUM_IFACES   = 1,
  parameter int NUM_EPS      = 2,
  parameter int MAX_PACKET   = 64,
  parameter bit HS_CAPABLE   = 1'b1
) (
  // Clock and reset.
  input  wire logic                    i_clock,
  input  wire logic                    i_resetn,
  // Setup packet fields.
  input  wire logic                    i_setup_valid,
  input  wire logic [7:0]              i_bm_request_type,
  input  wire logic [7:0]              i_b_request,
  input  wire logic [15:0]             i_w_value,
  input  wire logic [15:0]             i_w_index,
  input  wire logic [15:0]             i_w_length,
  // Device context from the enumeration logic.
  input  wire logic [1:0]              i_dev_state,
  input  wire logic [7:0]              i_config_value,
  input  wire logic [NUM_IFACES*8-1:0] i_alt_setting,
  input  wire logic                    i_bus_reset,
  input  wire logic                    i_setting_applied,
  input  wire logic                    i_self_powered,
  input  wire logic                    i_ctrl_halt,
  input  wire logic [NUM_EPS-1:0]      i_ep_hw_halt,
  // Descriptor store lookup and read.
  output logic                         o_desc_req,
  output logic [7:0]                   o_desc_type,
  output logic [7:0]                   o_desc_index,
  output logic [15:0]                  o_desc_lang,
  input  wire logic                    i_desc_ack,
  input  wire logic                    i_desc_found,
  input  wire logic [15:0]             i_desc_length,
  output logic [15:0]                  o_rd_addr,
  input  wire logic [7:0]              i_rd_data,
  // Data stage byte stream.
  output logic                         o_tx_valid,
  output logic [7:0]                   o_tx_data,
  output logic                         o_tx_last,
  output logic                         o_tx_zlp,
  input  wire logic                    i_tx_ready,
  // Request outcome.
  output logic                         o_done,
  output logic                         o_stall,
  output logic                         o_pass,
  output logic                         o_busy,
  // Kept status bits and the one-cycle endpoint toggle reset pulses.
  output logic                         o_remote_wakeup_en,
  output logic [NUM_EPS-1:0]           o_ep_halt,
  output logic [NUM_EPS-1:0]           o_ep_toggle_reset
);

  localparam logic [15:0] PKT_MASK = 16'(MAX_PACKET - 1);

  usbg_dev_state_type dev_st;
  usbg_fsm_type       fsm_q, fsm_d;
  logic [15:0]        ptr_q, ptr_d, remain_q, remain_d, wlen_q, wlen_d, reply_q, reply_d;
  logic [7:0]         dtype_q, dtype_d, dindex_q, dindex_d, tx_data_q, tx_data_d;
  logic [15:0]        dlang_q, dlang_d;
  logic               local_q, local_d, zlp_q, zlp_d, last_q, last_d;
  logic               done_q, done_d, stall_q, stall_d, pass_q, pass_d;
  logic               wake_q, wake_d;
  logic [NUM_EPS-1:0] halt_q, halt_d, tog_q, tog_d;
  // Decode helpers.
  logic               req_std, dir_in, ep_exists, iface_exists, is_cfg;
  logic [4:0]         recip;
  logic [3:0]         ep_num;
  logic [7:0]         alt_sel;
  logic               halt_sel;
  logic               set_halt, clr_halt, set_wake, clr_wake;
  logic               start_go;
  logic [15:0]        start_len, xfer_len;

  assign dev_st  = usbg_dev_state_type'(i_dev_state);
  assign req_std = i_bm_request_type[USBG_RT_TYPE_LSB+1:USBG_RT_TYPE_LSB] == USBG_RT_STANDARD;
  assign dir_in  = i_bm_request_type[USBG_RT_DIR_BIT];
  assign recip   = i_bm_request_type[4:0];
  assign ep_num  = i_w_index[3:0];
  assign is_cfg  = dev_st == USBG_ST_CONFIGURED;

  // Endpoint and interface existence; endpoint zero always exists.
  assign ep_exists    = (i_w_index[15:8] == 8'h00) && (i_w_index[6:4] == 3'h0) &&
                        ((ep_num == 4'h0) || (ep_num <= 4'(NUM_EPS)));
  assign iface_exists = is_cfg && (i_w_index[15:8] == 8'h00) &&
                        (i_w_index[7:0] < 8'(NUM_IFACES));

  // Selects the alternate setting and halt bit named by wIndex.
  always_comb begin
    alt_sel  = 8'h00;
    halt_sel = i_ctrl_halt;
    for (int k = 0; k < NUM_IFACES; k++) begin
      if (i_w_index[7:0] == 8'(k)) begin
        alt_sel = i_alt_setting[k*8 +: 8];
      end
    end
    for (int k = 0; k < NUM_EPS; k++) begin
      if (ep_num == 4'(k + 1)) begin
        halt_sel = halt_q[k];
      end
    end
  end

  // Request decode and answer sequencer.
  always_comb begin
    fsm_d     = fsm_q;
    ptr_d     = ptr_q;
    remain_d  = remain_q;
    wlen_d    = wlen_q;
    reply_d   = reply_q;
    dtype_d   = dtype_q;
    dindex_d  = dindex_q;
    dlang_d   = dlang_q;
    local_d   = local_q;
    zlp_d     = zlp_q;
    last_d    = last_q;
    tx_data_d = tx_data_q;
    done_d    = 1'b0;
    stall_d   = 1'b0;
    pass_d    = 1'b0;
    set_halt  = 1'b0;
    clr_halt  = 1'b0;
    set_wake  = 1'b0;
    clr_wake  = 1'b0;
    start_go  = 1'b0;
    start_len = 16'h0000;
    xfer_len  = 16'h0000;
    if (i_setup_valid) begin
      // A new setup always abandons any answer still in flight.
      fsm_d   = USBG_FSM_IDLE;
      wlen_d  = i_w_length;
      ptr_d   = 16'h0000;
      local_d = 1'b1;
      if (!req_std) begin
        pass_d = 1'b1;
      end else if (i_ctrl_halt && (i_b_request != USBG_REQ_GET_STATUS) &&
                   (i_b_request != USBG_REQ_SET_FEATURE) &&
                   (i_b_request != USBG_REQ_CLEAR_FEATURE)) begin
        stall_d = 1'b1;
      end else begin
        case (i_b_request)
          USBG_REQ_GET_CONFIG: begin
            // Unspecified field values and the Default state are refused.
            if (i_bm_request_type == 8'h80 && i_w_value == 16'h0000 && i_w_index == 16'h0000 &&
                i_w_length == USBG_LEN_ONE && dev_st != USBG_ST_DEFAULT) begin
              reply_d   = {8'h00, is_cfg ? i_config_value : 8'h00};
              start_go  = 1'b1;
              start_len = USBG_LEN_ONE;
            end else begin
              stall_d = 1'b1;
            end
          end
          USBG_REQ_GET_DESCR: begin
            dtype_d  = i_w_value[15:8];
            dindex_d = i_w_value[7:0];
            dlang_d  = (i_w_value[15:8] == USBG_DT_STRING) ? i_w_index : 16'h0000;
            if (i_bm_request_type != 8'h80) begin
              stall_d = 1'b1;
            end else if (i_w_value[15:8] == USBG_DT_CONFIG || i_w_value[15:8] == USBG_DT_STRING) begin
              fsm_d = USBG_FSM_LOOKUP;
            end else if ((i_w_value[15:8] == USBG_DT_DEVICE ||
                          (HS_CAPABLE && (i_w_value[15:8] == USBG_DT_QUALIFIER ||
                                          i_w_value[15:8] == USBG_DT_OTHER_CFG))) &&
                         i_w_value[7:0] == 8'h00) begin
              fsm_d = USBG_FSM_LOOKUP;
            end else begin
              stall_d = 1'b1;
            end
          end
          USBG_REQ_GET_IFACE: begin
            if (i_bm_request_type == 8'h81 && i_w_value == 16'h0000 && i_w_length == USBG_LEN_ONE &&
                iface_exists) begin
              reply_d   = {8'h00, alt_sel};
              start_go  = 1'b1;
              start_len = USBG_LEN_ONE;
            end else begin
              stall_d = 1'b1;
            end
          end
          USBG_REQ_GET_STATUS: begin
            start_len = USBG_LEN_TWO;
            if (!dir_in || i_bm_request_type[6:5] != USBG_RT_STANDARD || i_w_value != 16'h0000 ||
                i_w_length != USBG_LEN_TWO || dev_st == USBG_ST_DEFAULT) begin
              stall_d = 1'b1;
            end else if (recip == USBG_RCP_DEVICE && i_w_index == 16'h0000) begin
              reply_d = 16'h0000;
              reply_d[USBG_ST_SELF_PWR_BIT] = i_self_powered;
              reply_d[USBG_ST_WAKEUP_BIT]   = wake_q;
              start_go = 1'b1;
            end else if (recip == USBG_RCP_IFACE && iface_exists) begin
              reply_d  = 16'h0000;
              start_go = 1'b1;
            end else if (recip == USBG_RCP_EP && ep_exists && (is_cfg || ep_num == 4'h0)) begin
              reply_d = 16'h0000;
              reply_d[USBG_ST_HALT_BIT] = halt_sel;
              start_go = 1'b1;
            end else begin
              stall_d = 1'b1;
            end
          end
          USBG_REQ_SET_FEATURE,
          USBG_REQ_CLEAR_FEATURE: begin
            if (dir_in || i_w_length != 16'h0000 || dev_st == USBG_ST_DEFAULT) begin
              stall_d = 1'b1;
            end else if (recip == USBG_RCP_DEVICE && i_w_value == USBG_FS_WAKEUP &&
                         i_w_index == 16'h0000) begin
              set_wake = i_b_request == USBG_REQ_SET_FEATURE;
              clr_wake = i_b_request == USBG_REQ_CLEAR_FEATURE;
              done_d   = 1'b1;
            end else if (recip == USBG_RCP_DEVICE && i_w_value == USBG_FS_TEST_MODE &&
                         i_b_request == USBG_REQ_SET_FEATURE) begin
              pass_d = 1'b1;
            end else if (recip == USBG_RCP_EP && i_w_value == USBG_FS_EP_HALT && ep_exists &&
                         (is_cfg || ep_num == 4'h0)) begin
              if (ep_num == 4'h0 && i_b_request == USBG_REQ_SET_FEATURE) begin
                stall_d = 1'b1;
              end else begin
                set_halt = i_b_request == USBG_REQ_SET_FEATURE;
                clr_halt = i_b_request == USBG_REQ_CLEAR_FEATURE;
                done_d   = 1'b1;
              end
            end else begin
              stall_d = 1'b1;
            end
          end
          default: begin
            pass_d = 1'b1;
          end
        endcase
      end
    end else begin
      case (fsm_q)
        USBG_FSM_LOOKUP: begin
          if (i_desc_ack) begin
            if (i_desc_found) begin
              local_d   = 1'b0;
              start_go  = 1'b1;
              start_len = i_desc_length;
            end else begin
              fsm_d   = USBG_FSM_IDLE;
              stall_d = 1'b1;
            end
          end
        end
        USBG_FSM_FETCH: begin
          tx_data_d = local_q ? (ptr_q[0] ? reply_q[15:8] : reply_q[7:0]) : i_rd_data;
          last_d    = remain_q == 16'h0001;
          fsm_d     = USBG_FSM_SEND;
        end
        USBG_FSM_SEND: begin
          if (i_tx_ready) begin
            ptr_d    = ptr_q + 16'h0001;
            remain_d = remain_q - 16'h0001;
            if (remain_q != 16'h0001) begin
              fsm_d = USBG_FSM_FETCH;
            end else if (zlp_q) begin
              fsm_d = USBG_FSM_ZLP;
            end else begin
              fsm_d  = USBG_FSM_IDLE;
              done_d = 1'b1;
            end
          end
        end
        USBG_FSM_ZLP: begin
          if (i_tx_ready) begin
            fsm_d  = USBG_FSM_IDLE;
            done_d = 1'b1;
          end
        end
        default: begin
          fsm_d = USBG_FSM_IDLE;
        end
      endcase
    end
    // Starts a data stage clipped to wLength.
    if (start_go) begin
      xfer_len = (start_len > wlen_d) ? wlen_d : start_len;
      remain_d = xfer_len;
      ptr_d    = 16'h0000;
      // A transfer that stops short on a packet boundary needs a zero-length packet.
      zlp_d    = (xfer_len < wlen_d) && ((xfer_len & PKT_MASK) == 16'h0000);
      if (xfer_len == 16'h0000) begin
        fsm_d  = USBG_FSM_IDLE;
        done_d = 1'b1;
      end else begin
        fsm_d = USBG_FSM_FETCH;
      end
    end
    // A bus reset drops any answer in flight.
    if (i_bus_reset) begin
      fsm_d = USBG_FSM_IDLE;
    end
  end

  // Remote wakeup enable is set or cleared by its feature requests and cleared by a bus reset unless a set request comes in the same cycle.
  always_comb begin
    wake_d = wake_q;
    if (set_wake) begin
      wake_d = 1'b1;
    end else if (clr_wake || i_bus_reset) begin
      wake_d = USBG_WAKEUP_RESET;
    end
  end

  // Per-endpoint halt bit and toggle reset.
  for (genvar g = 0; g < NUM_EPS; g++) begin : g_ep
    logic hit;
    assign hit = ep_num == 4'(g + 1);
    always_comb begin
      halt_d[g] = halt_q[g];
      tog_d[g]  = clr_halt && hit;
      if (i_bus_reset || i_setting_applied || (clr_halt && hit)) begin
        halt_d[g] = USBG_HALT_RESET;
      end
      // A standing hardware cause or a set request wins over any clear.
      if (i_ep_hw_halt[g] || (set_halt && hit)) begin
        halt_d[g] = 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fsm_q     <= USBG_FSM_IDLE;
      ptr_q     <= 16'h0000;
      remain_q  <= 16'h0000;
      wlen_q    <= 16'h0000;
      reply_q   <= 16'h0000;
      dtype_q   <= 8'h00;
      dindex_q  <= 8'h00;
      dlang_q   <= 16'h0000;
      local_q   <= 1'b1;
      zlp_q     <= 1'b0;
      last_q    <= 1'b0;
      tx_data_q <= 8'h00;
      done_q    <= 1'b0;
      stall_q   <= 1'b0;
      pass_q    <= 1'b0;
      wake_q    <= USBG_WAKEUP_RESET;
      halt_q    <= {NUM_EPS{USBG_HALT_RESET}};
      tog_q     <= '0;
    end else begin
      fsm_q     <= fsm_d;
      ptr_q     <= ptr_d;
      remain_q  <= remain_d;
      wlen_q    <= wlen_d;
      reply_q   <= reply_d;
      dtype_q   <= dtype_d;
      dindex_q  <= dindex_d;
      dlang_q   <= dlang_d;
      local_q   <= local_d;
      zlp_q     <= zlp_d;
      last_q    <= last_d;
      tx_data_q <= tx_data_d;
      done_q    <= done_d;
      stall_q   <= stall_d;
      pass_q    <= pass_d;
      wake_q    <= wake_d;
      halt_q    <= halt_d;
      tog_q     <= tog_d;
    end
  end

  // Outputs.
  assign o_desc_req         = fsm_q == USBG_FSM_LOOKUP;
  assign o_desc_type        = dtype_q;
  assign o_desc_index       = dindex_q;
  assign o_desc_lang        = dlang_q;
  assign o_rd_addr          = ptr_q;
  assign o_tx_valid         = (fsm_q == USBG_FSM_SEND) || (fsm_q == USBG_FSM_ZLP);
  assign o_tx_data          = tx_data_q;
  assign o_tx_last          = last_q;
  assign o_tx_zlp           = fsm_q == USBG_FSM_ZLP;
  assign o_done             = done_q;
  assign o_stall            = stall_q;
  assign o_pass             = pass_q;
  assign o_busy             = fsm_q != USBG_FSM_IDLE;
  assign o_remote_wakeup_en = wake_q;
  assign o_ep_halt          = halt_q;
  assign o_ep_toggle_reset  = tog_q;

endmodule

/* bench/usbg_props_properties.sv */
// Checker of the responder's ports.
`timescale 1ns/100ps
module usbg_props
  import usbg_pkg::*;
#(parameter int NUM_EPS = 2) (
  // Watched ports.
  input wire logic                i_clock, i_resetn, i_setup_valid, i_bus_reset, i_setting_applied, i_tx_ready,
  input wire logic [7:0]          i_b_request, o_desc_type, o_tx_data,
  input wire logic [1:0]          i_dev_state,
  input wire logic [15:0]         o_desc_lang,
  input wire logic [NUM_EPS-1:0]  i_ep_hw_halt, o_ep_halt, o_ep_toggle_reset,
  input wire logic                o_desc_req, o_tx_valid, o_tx_zlp, o_stall, o_remote_wakeup_en
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Setups of two request codes.
  wire logic cfg_rq = i_setup_valid && i_b_request == USBG_REQ_GET_CONFIG;
  wire logic if_rq  = i_setup_valid && i_b_request == USBG_REQ_GET_IFACE;
  property p_lang; o_desc_req && o_desc_type != USBG_DT_STRING |-> o_desc_lang == 16'h0000; endproperty
  a_lang: assert property (p_lang) else $error("language not zero");
  property p_cfg_dflt; cfg_rq && i_dev_state == USBG_ST_DEFAULT |=> o_stall; endproperty
  a_cfg_dflt: assert property (p_cfg_dflt) else $error("default not stalled");
  property p_if_addr; if_rq && i_dev_state == USBG_ST_ADDRESS |=> o_stall; endproperty
  a_if_addr: assert property (p_if_addr) else $error("iface not stalled");
  property p_wk_rst; i_bus_reset && !i_setup_valid && !$past(i_setup_valid) |=> !o_remote_wakeup_en; endproperty
  a_wk_rst: assert property (p_wk_rst) else $error("wakeup kept");
  property p_wk_cause; $changed(o_remote_wakeup_en) |-> $past(i_setup_valid) || $past(i_bus_reset); endproperty
  a_wk_cause: assert property (p_wk_cause) else $error("wakeup self change");
  property p_hw; |i_ep_hw_halt |=> (o_ep_halt & $past(i_ep_hw_halt)) == $past(i_ep_hw_halt); endproperty
  a_hw: assert property (p_hw) else $error("hw halt lost");
  property p_applied;
    i_setting_applied && i_ep_hw_halt == '0 && !i_setup_valid && !$past(i_setup_valid) |=> o_ep_halt == '0;
  endproperty
  a_applied: assert property (p_applied) else $error("halt kept");
  property p_tog; |o_ep_toggle_reset |=> o_ep_toggle_reset == '0; endproperty
  a_tog: assert property (p_tog) else $error("toggle long");
  property p_hold; o_tx_valid && !i_tx_ready && !i_setup_valid && !i_bus_reset |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  // Main scenarios.
  c_zlp: cover property (o_tx_valid && o_tx_zlp && i_tx_ready);
  c_stall: cover property (o_stall);
  c_tog: cover property (|o_ep_toggle_reset);
endmodule
bind usbg_get_responder usbg_props #(.NUM_EPS(NUM_EPS)) props_u (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_setup_valid(i_setup_valid), .i_bus_reset(i_bus_reset), .i_setting_applied(i_setting_applied),
  .i_tx_ready(i_tx_ready), .i_b_request(i_b_request), .o_desc_type(o_desc_type), .o_tx_data(o_tx_data),
  .i_dev_state(i_dev_state), .o_desc_lang(o_desc_lang), .i_ep_hw_halt(i_ep_hw_halt), .o_ep_halt(o_ep_halt),
  .o_ep_toggle_reset(o_ep_toggle_reset), .o_desc_req(o_desc_req), .o_tx_valid(o_tx_valid),
  .o_tx_zlp(o_tx_zlp), .o_stall(o_stall), .o_remote_wakeup_en(o_remote_wakeup_en));

/* bench/usbg_store_model.sv */
// Descriptor store and host ready model.
`timescale 1ns/100ps
module usbg_store_model (
  // Lookup and read.
  input wire logic        i_clock, i_req,
  input wire logic [7:0]  i_type, i_index,
  input wire logic [15:0] i_lang, i_addr,
  output logic            o_ack, o_found, o_ready,
  output logic [15:0]     o_length,
  output logic [7:0]      o_data
);
  logic [1:0]  wait_q;
  logic [1:0]  rdy_q = 2'h0;
  logic [15:0] len;
  // Known blocks; a nonzero index finds nothing.
  always_comb begin
    case (i_type)
      8'h01:   len = 16'h0012;
      8'h02:   len = 16'h0040;
      8'h03:   len = (i_lang == 16'h0409) ? 16'h0004 : 16'h0000;
      8'h06:   len = 16'h000a;
      default: len = 16'h0000;
    endcase
    if (i_index != 8'h00) len = 16'h0000;
  end
  // Answer two cycles late; ready drops one cycle in three.
  always_ff @(posedge i_clock) begin
    wait_q <= (i_req && !o_ack) ? wait_q + 2'h1 : 2'h0;
    rdy_q  <= (rdy_q == 2'h2) ? 2'h0 : rdy_q + 2'h1;
  end
  // The byte is read in the cycle its offset stands; result lines show the inverse outside the answer.
  assign o_data   = i_addr[7:0] + 8'h30;
  assign o_ack    = i_req && wait_q == 2'h2;
  assign o_found  = o_ack ? (len != 16'h0000) : (len == 16'h0000);
  assign o_length = o_ack ? len : ~len;
  assign o_ready  = rdy_q != 2'h2;
endmodule

/* bench/tb.sv */
// Bench of the get-request responder.
`timescale 1ns/100ps
module tb;
  import usbg_pkg::*;
  typedef struct {logic [1:0] st; logic [7:0] bm, rq; logic [15:0] wi, wl, ex; logic stl; int n;} usbg_row_type;
  logic        i_clock = 1'b0, i_resetn = 1'b0, i_setup_valid = 1'b0, i_bus_reset = 1'b0, i_setting_applied = 1'b0;
  logic        i_self_powered = 1'b1, i_ctrl_halt = 1'b0;
  logic [7:0]  i_bm_request_type = 8'h00, i_b_request = 8'h00, i_config_value = 8'h05, i_alt_setting = 8'h03;
  logic [15:0] i_w_value = 16'h0000, i_w_index = 16'h0000, i_w_length = 16'h0000;
  logic [1:0]  i_dev_state = 2'h1, i_ep_hw_halt = 2'h0, ep_halt, tog, got_tog;
  logic        desc_req, desc_ack, desc_found, tx_valid, tx_last, tx_zlp, tx_ready, done, stall, pass, busy, wake;
  logic [7:0]  desc_type, desc_index, rd_data, tx_data;
  logic [7:0]  got [0:127];
  logic [15:0] desc_lang, desc_len, rd_addr;
  logic        got_zlp, got_stall, got_done;
  int          err_count = 0, checks_done = 0, got_n;
  usbg_row_type rows [13];
  always #12.5 i_clock = ~i_clock;
  usbg_get_responder dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_setup_valid(i_setup_valid),
    .i_bm_request_type(i_bm_request_type), .i_b_request(i_b_request), .i_w_value(i_w_value),
    .i_w_index(i_w_index), .i_w_length(i_w_length), .i_dev_state(i_dev_state), .i_config_value(i_config_value),
    .i_alt_setting(i_alt_setting), .i_bus_reset(i_bus_reset), .i_setting_applied(i_setting_applied),
    .i_self_powered(i_self_powered), .i_ctrl_halt(i_ctrl_halt), .i_ep_hw_halt(i_ep_hw_halt),
    .o_desc_req(desc_req), .o_desc_type(desc_type), .o_desc_index(desc_index), .o_desc_lang(desc_lang),
    .i_desc_ack(desc_ack), .i_desc_found(desc_found), .i_desc_length(desc_len), .o_rd_addr(rd_addr),
    .i_rd_data(rd_data), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last), .o_tx_zlp(tx_zlp),
    .i_tx_ready(tx_ready), .o_done(done), .o_stall(stall), .o_pass(pass), .o_busy(busy),
    .o_remote_wakeup_en(wake), .o_ep_halt(ep_halt), .o_ep_toggle_reset(tog));
  usbg_store_model store_u (.i_clock(i_clock), .i_req(desc_req), .i_type(desc_type), .i_index(desc_index),
    .i_lang(desc_lang), .i_addr(rd_addr), .o_ack(desc_ack), .o_found(desc_found), .o_ready(tx_ready),
    .o_length(desc_len), .o_data(rd_data));
  // Compares and verdict.
  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(string nm, logic e, logic g);
    chk_val(nm, {15'h0, e}, {15'h0, g});
  endtask
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One request, collecting accepted items until the outcome.
  task automatic do_req(logic [7:0] bm, logic [7:0] rq, logic [15:0] wv, logic [15:0] wi, logic [15:0] wl);
    int t;
    @(negedge i_clock);
    {i_bm_request_type, i_b_request, i_w_value, i_w_index, i_w_length} = {bm, rq, wv, wi, wl};
    i_setup_valid = 1'b1;
    {got_n, got_zlp, got_tog} = '0;
    @(negedge i_clock);
    i_setup_valid = 1'b0;
    for (t = 0; t < 600; t++) begin
      got_tog |= tog;
      if (tx_valid === 1'b1 && tx_ready && tx_zlp === 1'b1) got_zlp = 1'b1;
      else if (tx_valid === 1'b1 && tx_ready && got_n < 128) got[got_n++] = tx_data;
      if (done === 1'b1 || stall === 1'b1 || pass === 1'b1) break;
      @(negedge i_clock);
    end
    {got_done, got_stall} = {done, stall};
    if (t == 600) begin
      err_count++;
      give_verdict;
    end
    @(negedge i_clock);
    got_tog |= tog;
  endtask
  // Descriptor bytes are offset plus 30 hex.
  task automatic chk_desc(int n, logic z);
    chk_flag("desc done", 1'b1, got_done);
    chk_val("desc count", 16'(n), 16'(got_n));
    chk_flag("desc zlp", z, got_zlp);
    for (int k = 0; k < n; k++) chk_val("desc byte", {8'h00, 8'(k) + 8'h30}, {8'h00, got[k]});
  endtask
  initial begin
    rows = '{'{2'h1, 8'h80, 8'h08, 16'h0000, 16'h0001, 16'h0000, 1'b0, 1}, '{2'h2, 8'h80, 8'h08, 16'h0000,
      16'h0001, 16'h0005, 1'b0, 1}, '{2'h2, 8'h81, 8'h0a, 16'h0000, 16'h0001, 16'h0003, 1'b0, 1},
      '{2'h1, 8'h81, 8'h0a, 16'h0000, 16'h0001, 16'h0000, 1'b1, 0}, '{2'h2, 8'h81, 8'h0a, 16'h0001, 16'h0001,
      16'h0000, 1'b1, 0}, '{2'h1, 8'h80, 8'h00, 16'h0000, 16'h0002, 16'h0001, 1'b0, 2}, '{2'h2, 8'h81, 8'h00,
      16'h0000, 16'h0002, 16'h0000, 1'b0, 2}, '{2'h1, 8'h81, 8'h00, 16'h0000, 16'h0002, 16'h0000, 1'b1, 0},
      '{2'h1, 8'h82, 8'h00, 16'h0000, 16'h0002, 16'h0000, 1'b0, 2}, '{2'h1, 8'h82, 8'h00, 16'h0081, 16'h0002,
      16'h0000, 1'b1, 0}, '{2'h2, 8'h82, 8'h00, 16'h0003, 16'h0002, 16'h0000, 1'b1, 0}, '{2'h0, 8'h80, 8'h08,
      16'h0000, 16'h0001, 16'h0000, 1'b1, 0}, '{2'h2, 8'h82, 8'h00, 16'h0081, 16'h0002, 16'h0000, 1'b0, 2}};
    repeat (20) @(negedge i_clock);
    i_resetn = 1'b1;
    chk_val("reset state", 16'h0000, {13'h0, wake, ep_halt});
    // Fixed-size answers and refusals.
    foreach (rows[i]) begin
      i_dev_state = rows[i].st;
      do_req(rows[i].bm, rows[i].rq, 16'h0000, rows[i].wi, rows[i].wl);
      chk_flag("row stall", rows[i].stl, got_stall);
      chk_val("row count", 16'(rows[i].n), 16'(got_n));
      for (int k = 0; k < rows[i].n; k++) chk_val("row byte", {8'h00, rows[i].ex[k*8+:8]}, {8'h00, got[k]});
    end
    // Descriptors: clipped, block with empty packet, string, qualifier, missing.
    i_dev_state = USBG_ST_DEFAULT;
    do_req(8'h80, USBG_REQ_GET_DESCR, 16'h0100, 16'h0000, 16'h0008);
    chk_desc(8, 1'b0);
    i_dev_state = USBG_ST_CONFIGURED;
    do_req(8'h80, USBG_REQ_GET_DESCR, 16'h0200, 16'h0000, 16'h00ff);
    chk_desc(64, 1'b1);
    do_req(8'h80, USBG_REQ_GET_DESCR, 16'h0300, 16'h0409, 16'h00ff);
    chk_desc(4, 1'b0);
    chk_val("desc lang", 16'h0409, desc_lang);
    do_req(8'h80, USBG_REQ_GET_DESCR, 16'h0600, 16'h0000, 16'h000a);
    chk_desc(10, 1'b0);
    do_req(8'h80, USBG_REQ_GET_DESCR, 16'h0400, 16'h0000, 16'h0009);
    chk_flag("missing desc", 1'b1, got_stall);
    // Wakeup set by request, cleared by reset.
    do_req(8'h00, USBG_REQ_SET_FEATURE, USBG_FS_WAKEUP, 16'h0000, 16'h0000);
    do_req(8'h80, USBG_REQ_GET_STATUS, 16'h0000, 16'h0000, 16'h0002);
    chk_val("dev status", 16'h0003, {got[1], got[0]});
    i_bus_reset = 1'b1;
    @(negedge i_clock);
    i_bus_reset = 1'b0;
    chk_flag("wakeup cleared", 1'b0, wake);
    // Halt by request; each clear resets the toggle.
    do_req(8'h02, USBG_REQ_SET_FEATURE, USBG_FS_EP_HALT, 16'h0001, 16'h0000);
    do_req(8'h82, USBG_REQ_GET_STATUS, 16'h0000, 16'h0001, 16'h0002);
    chk_val("ep status", 16'h0001, {got[1], got[0]});
    repeat (2) begin
      do_req(8'h02, USBG_REQ_CLEAR_FEATURE, USBG_FS_EP_HALT, 16'h0001, 16'h0000);
      chk_val("halt and toggle", 16'h0100, {6'h0, got_tog, 6'h0, ep_halt});
    end
    // Both halts cleared by a new setting.
    do_req(8'h02, USBG_REQ_SET_FEATURE, USBG_FS_EP_HALT, 16'h0002, 16'h0000);
    i_ep_hw_halt = 2'h1;
    @(negedge i_clock);
    chk_val("halts set", 16'h0003, {14'h0, ep_halt});
    {i_ep_hw_halt, i_setting_applied} = 3'h1;
    @(negedge i_clock);
    i_setting_applied = 1'b0;
    chk_val("halts cleared", 16'h0000, {14'h0, ep_halt});
    // Default-pipe halt stalls a query but not status.
    i_ctrl_halt = 1'b1;
    do_req(8'h80, USBG_REQ_GET_CONFIG, 16'h0000, 16'h0000, 16'h0001);
    chk_flag("halted pipe", 1'b1, got_stall);
    do_req(8'h82, USBG_REQ_GET_STATUS, 16'h0000, 16'h0000, 16'h0002);
    chk_val("ep0 status", 16'h0001, {got[1], got[0]});
    give_verdict;
  end
endmodule
